// File: design/mrr_byte_rotator.v
// byte-alignment datapath between the corrected array bus and host-side bus
// assumes all controls come from same-clock microcode logic; the phase zero
// clock arrives as a one-cycle enable pulse on i_core_clk
`timescale 1ns/1ps
`include "mrr_consts.vh"
module mrr_byte_rotator (
  input  wire                    i_core_clk,
  input  wire                    i_reset,
  // array side
  input  wire [`MRR_DATA_W-1:0]  i_array_data,
  input  wire                    i_array_valid,
  output wire                    o_array_ready,
  output reg  [`MRR_DATA_W-1:0]  o_array_wr_data,
  // microcode controls
  input  wire                    i_rotate_code_low,
  input  wire                    i_rotate_code_high,
  input  wire                    i_read_output_enable,
  input  wire [`MRR_SPF_W-1:0]   i_spf_code,
  input  wire                    i_phase_zero_clock,
  input  wire                    i_two_cycle_read,
  output wire                    o_second_cycle_flag,
  // host side
  input  wire [`MRR_DATA_W-1:0]  i_host_wr_data,
  output wire [`MRR_DATA_W-1:0]  o_host_bus_data,
  output wire                    o_host_bus_valid,
  input  wire                    i_host_bus_ready,
  output wire [`MRR_FIFO_AW:0]   o_fifo_level
);

  // ----------------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------------
  // flag is a pure decode, so it is true only while the microword says so
  function is_second_cycle;
    input [`MRR_SPF_W-1:0] spf;
    begin
      is_second_cycle = (spf == `MRR_SPF_SECOND);
    end
  endfunction

  // lanes that carry first-longword bytes after a right shift of n
  function [3:0] first_mask;
    input [1:0] n;
    begin
      first_mask = `MRR_ALL_LANES >> n;
    end
  endfunction

  wire [1:0] rot_code    = {i_rotate_code_high, i_rotate_code_low};
  wire       second_cyc  = is_second_cycle(i_spf_code);
  wire       en_primary  = i_read_output_enable;
  wire       en_second   = i_read_output_enable & ~second_cyc;
  wire       en_write    = ~i_read_output_enable & ~second_cyc;
  wire       en_feedback = second_cyc;

  assign o_second_cycle_flag = second_cyc;

  // ----------------------------------------------------------------------
  // the three rotators
  // ----------------------------------------------------------------------
  wire [31:0] prim_out;
  wire [31:0] sec_out;
  wire [31:0] wr_out;

  // two read rotators and one write rotator
  mrr_rotator #(.LEFT(0)) u_rot_primary (
    .i_data   (i_array_data),
    .i_code   (rot_code),
    .i_enable (en_primary),
    .o_data   (prim_out)
  );

  mrr_rotator #(.LEFT(0)) u_rot_secondary (
    .i_data   (i_array_data),
    .i_code   (rot_code),
    .i_enable (en_second),
    .o_data   (sec_out)
  );

  // same code as the reads, opposite direction
  mrr_rotator #(.LEFT(1)) u_rot_write (
    .i_data   (i_host_wr_data),
    .i_code   (rot_code),
    .i_enable (en_write),
    .o_data   (wr_out)
  );

  // ----------------------------------------------------------------------
  // holding register
  // ----------------------------------------------------------------------
  reg  [31:0] holding_register;
  // or-merge of three gated sources; only one is ever enabled
  wire [31:0] next_holding = sec_out | wr_out | (en_feedback ? holding_register : 32'h00000000);

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      holding_register <= `MRR_HOLD_RST;
    end else if (i_phase_zero_clock) begin
      holding_register <= next_holding;
    end
  end

  // write data leaves rotated only; lane selection is the ecc stage's job
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_array_wr_data <= `MRR_HOLD_RST;
    end else begin
      o_array_wr_data <= holding_register;
    end
  end

  // ----------------------------------------------------------------------
  // byte selectors and merge
  // ----------------------------------------------------------------------
  wire [3:0]  keep_first = first_mask(rot_code);
  wire [31:0] first_sel;
  wire [31:0] second_sel;
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_sel
      // first-cycle selector on the holding register
      assign first_sel[b*8 +: 8]  = keep_first[b] ? holding_register[b*8 +: 8] : 8'h00;
      // second-cycle selector on the primary rotator
      assign second_sel[b*8 +: 8] = keep_first[b] ? 8'h00 : prim_out[b*8 +: 8];
    end
  endgenerate

  // second cycle: first-cycle bytes low, second-longword bytes high
  // one-cycle read: primary output straight through, no selector
  // unrequested high lanes still carry bytes; the master drops them
  wire [31:0] bus_word = second_cyc ? (first_sel | second_sel) : prim_out;

  // first cycle of a two-cycle read only loads the holding register
  wire deliver = i_array_valid & i_read_output_enable & (second_cyc | ~i_two_cycle_read);
  wire fifo_in_ready;

  // array data is consumed when delivered or when it only feeds the holding register
  assign o_array_ready = fifo_in_ready | ~deliver;

  // ----------------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------------
  mrr_fifo #(
    .WIDTH (`MRR_DATA_W),
    .DEPTH (`MRR_FIFO_DEPTH),
    .AW    (`MRR_FIFO_AW)
  ) u_out_fifo (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_in_data   (bus_word),
    .i_in_valid  (deliver),
    .o_in_ready  (fifo_in_ready),
    .o_out_data  (o_host_bus_data),
    .o_out_valid (o_host_bus_valid),
    .i_out_ready (i_host_bus_ready),
    .o_level     (o_fifo_level)
  );

endmodule // mrr_byte_rotator

// File: design/mrr_fifo.v
// flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module mrr_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_core_clk,
  input  wire             i_reset,
  input  wire [WIDTH-1:0] i_in_data,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  output wire [WIDTH-1:0] o_out_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [AW:0]      o_level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire do_push = i_in_valid & o_in_ready;
  wire do_pop  = o_out_valid & i_out_ready;

  assign o_in_ready  = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data  = mem[rd_ptr];
  assign o_level     = count;

  // ----------------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop & ~do_push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // mrr_fifo

// File: design/mrr_rotator.v
// one byte rotator: a four-way lane multiplexer steered by a two-bit code
// assumes a same-clock code; purely combinational
`timescale 1ns/1ps
module mrr_rotator #(
  parameter LEFT = 0
) (
  input  wire [31:0] i_data,
  input  wire [1:0]  i_code,
  input  wire        i_enable,
  output wire [31:0] o_data
);

  // ----------------------------------------------------------------------
  // lane steering
  // ----------------------------------------------------------------------
  // each output lane picks one of four input lanes
  function [7:0] pick_lane;
    input [31:0] data;
    input [1:0]  sel;
    begin
      case (sel)
        2'h0:    pick_lane = data[7:0];
        2'h1:    pick_lane = data[15:8];
        2'h2:    pick_lane = data[23:16];
        default: pick_lane = data[31:24];
      endcase
    end
  endfunction

  wire [31:0] rotated;
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      // right moves lane+code down to lane, left moves lane-code up
      // sums kept wide and sliced, so the wrap modulo four is explicit
      wire [31:0] src_right = lane + i_code;
      wire [31:0] src_left  = lane + 4 - i_code;
      wire [1:0]  src       = LEFT ? src_left[1:0] : src_right[1:0];
      assign rotated[lane*8 +: 8] = pick_lane(i_data, src);
    end
  endgenerate

  // a disabled rotator contributes nothing to the or-merge
  assign o_data = i_enable ? rotated : 32'h00000000;

endmodule // mrr_rotator

// File: dv/mrr_byte_rotator_props.sv
// port checker for the byte rotator datapath
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module mrr_byte_rotator_props (
  input wire logic        i_core_clk,
  input wire logic        i_reset,
  input wire logic [31:0] i_array_data,
  input wire logic        i_array_valid,
  input wire logic        o_array_ready,
  input wire logic [31:0] o_array_wr_data,
  input wire logic        i_rotate_code_low,
  input wire logic        i_rotate_code_high,
  input wire logic        i_read_output_enable,
  input wire logic [2:0]  i_spf_code,
  input wire logic        i_phase_zero_clock,
  input wire logic        i_two_cycle_read,
  input wire logic        o_second_cycle_flag,
  input wire logic [31:0] i_host_wr_data,
  input wire logic [31:0] o_host_bus_data,
  input wire logic [4:0]  o_fifo_level
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire [4:0]  sh   = {i_rotate_code_high, i_rotate_code_low, 3'h0};
  wire [31:0] rd_r = (i_array_data >> sh) | (i_array_data << (6'h20 - sh));
  wire [31:0] wr_r = (i_host_wr_data << sh) | (i_host_wr_data >> (6'h20 - sh));
  wire        rd   = i_read_output_enable;
  wire        sc   = o_second_cycle_flag;
  wire        push = i_array_valid && o_array_ready && rd && (sc || !i_two_cycle_read);
  property p_flag; sc == (i_spf_code == 3'h5); endproperty
  a_flag: assert property (p_flag) else $error("flag decode wrong");
  property p_one; push && !sc && o_fifo_level == 5'h00 |=> o_host_bus_data == $past(rd_r); endproperty
  a_one: assert property (p_one) else $error("read word misrotated");
  property p_rdy; o_fifo_level < 5'h10 |-> o_array_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("array refused with room");
  property p_lvl; !push |=> o_fifo_level <= $past(o_fifo_level); endproperty
  a_lvl: assert property (p_lvl) else $error("word appeared unasked");
  property p_wr; i_phase_zero_clock && !rd && !sc |-> ##2 o_array_wr_data == $past(wr_r, 2); endproperty
  a_wr: assert property (p_wr) else $error("write data misrotated");
  property p_first; i_phase_zero_clock && rd && !sc |-> ##2 o_array_wr_data == $past(rd_r, 2); endproperty
  a_first: assert property (p_first) else $error("first cycle load wrong");
  property p_reload; i_phase_zero_clock && sc |-> ##2 $stable(o_array_wr_data); endproperty
  a_reload: assert property (p_reload) else $error("reload changed data");
  property p_keep; !i_phase_zero_clock [*2] |=> $stable(o_array_wr_data); endproperty
  a_keep: assert property (p_keep) else $error("holding moved unclocked");
endmodule // mrr_byte_rotator_props

bind mrr_byte_rotator mrr_byte_rotator_props u_props (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_array_data(i_array_data),
  .i_array_valid(i_array_valid), .o_array_ready(o_array_ready),
  .o_array_wr_data(o_array_wr_data), .i_rotate_code_low(i_rotate_code_low),
  .i_rotate_code_high(i_rotate_code_high), .i_read_output_enable(i_read_output_enable),
  .i_spf_code(i_spf_code), .i_phase_zero_clock(i_phase_zero_clock),
  .i_two_cycle_read(i_two_cycle_read), .o_second_cycle_flag(o_second_cycle_flag),
  .i_host_wr_data(i_host_wr_data), .o_host_bus_data(o_host_bus_data),
  .o_fifo_level(o_fifo_level));

// File: dv/mrr_byte_rotator_tb.sv
// self-checking bench for the byte rotator datapath
// assumes the host model pops the fifo unless told to stall
`timescale 1ns/1ps
module mrr_byte_rotator_tb;
  logic        clk, rst, av, roe, two, pz, stall;
  logic [1:0]  code;
  logic [2:0]  spf;
  logic [31:0] ad, hw;
  wire         ardy, vld, flag, hrdy;
  wire  [31:0] wrd, hd, word;
  wire  [4:0]  lvl;
  wire  [7:0]  cnt;
  int          n_errors = 0, n_tests = 0, seen = 0;

  mrr_byte_rotator dut (.i_core_clk(clk), .i_reset(rst), .i_array_data(ad),
    .i_array_valid(av), .o_array_ready(ardy), .o_array_wr_data(wrd),
    .i_rotate_code_low(code[0]), .i_rotate_code_high(code[1]),
    .i_read_output_enable(roe), .i_spf_code(spf), .i_phase_zero_clock(pz),
    .i_two_cycle_read(two), .o_second_cycle_flag(flag), .i_host_wr_data(hw),
    .o_host_bus_data(hd), .o_host_bus_valid(vld), .i_host_bus_ready(hrdy),
    .o_fifo_level(lvl));
  mrr_host_model host (.i_core_clk(clk), .i_reset(rst), .i_stall(stall),
    .i_valid(vld), .i_data(hd), .o_ready(hrdy), .o_word(word), .o_count(cnt));

  function automatic [31:0] rr(input [31:0] d, input [1:0] n);
    rr = (d >> {n, 3'h0}) | (d << (6'h20 - {n, 3'h0}));
  endfunction
  function automatic [31:0] lr(input [31:0] d, input [1:0] n);
    lr = (d << {n, 3'h0}) | (d >> (6'h20 - {n, 3'h0}));
  endfunction
  task automatic chk(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input v, r, t, input [2:0] s, input p, input [1:0] c, input [31:0] d);
    @(posedge clk);
    av <= v; roe <= r; two <= t; spf <= s; pz <= p; code <= c; ad <= d; hw <= d;
  endtask
  task automatic pop(input [31:0] e, input [31:0] m);
    for (int k = 0; k < 40 && cnt === seen[7:0]; k++) @(negedge clk);
    seen++;
    chk(cnt, seen);
    chk(word & m, e & m);
  endtask

  task automatic t_one;
    for (int n = 0; n < 4; n++) begin
      // other special-function codes must leave the selectors out
      put(1, 1, 0, {n[1:0], 1'b0}, 0, n[1:0], 32'hA1B2C3D4 + n);
      put(0, 1, 0, 0, 0, 0, 0);
      pop(rr(32'hA1B2C3D4 + n, n[1:0]), n[0] ? 32'h0000FFFF : '1);
    end
  endtask
  task automatic t_two;
    logic [31:0] a, b, lo;
    for (int n = 0; n < 4; n++) begin
      a = 32'h11223344 ^ n;
      b = 32'h55667788 ^ n;
      lo = 32'hFFFFFFFF >> (8 * n);
      put(1, 1, 1, 0, 1, n[1:0], a);
      put(1, 1, 1, 5, 1, n[1:0], b);
      @(negedge clk);
      chk(flag, 32'h1);
      put(0, 1, 0, 0, 0, 0, 0);
      pop((rr(a, n[1:0]) & lo) | (rr(b, n[1:0]) & ~lo), '1);
    end
  endtask
  task automatic t_wr;
    for (int n = 0; n < 4; n++) begin
      put(0, 0, 0, 0, 1, n[1:0], 32'hC0FFEE00 + n);
      put(0, 0, 0, 5, 1, 0, 32'h0BADF00D);
      put(0, 0, 0, 0, 0, 0, 0);
      @(negedge clk);
      chk(wrd, lr(32'hC0FFEE00 + n, n[1:0]));
    end
  endtask
  task automatic t_fill;
    @(posedge clk);
    stall <= 1'b1;
    for (int i = 0; i < 17; i++) put(1, 1, 0, 0, 0, 0, i);
    @(negedge clk);
    chk(ardy, 32'h0);
    chk(lvl, 32'h10);
    chk(vld, 32'h1);
    put(0, 1, 0, 0, 0, 0, 0);
    stall <= 1'b0;
    for (int i = 0; i < 16; i++) pop(i, '1);
    @(negedge clk);
    chk(lvl, 32'h0);
    chk(vld, 32'h0);
  endtask

  // mid-run reset: a queued word and a loaded holding register must both clear
  task automatic t_rst;
    put(1, 1, 0, 0, 1, 2'h1, 32'h12345678);
    stall <= 1'b1;
    put(0, 1, 0, 0, 0, 0, 0);
    @(negedge clk);
    chk(lvl, 32'h1);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst   <= 1'b0;
    stall <= 1'b0;
    @(negedge clk);
    chk(lvl, 32'h0);
    chk(vld, 32'h0);
    chk(ardy, 32'h1);
    chk(wrd, 32'h0);
    chk(cnt, 32'h0);
    seen = 0;
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst = 1; av = 0; roe = 1; two = 0; spf = 0; pz = 0; code = 0; ad = 0; hw = 0; stall = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_one;
    t_two;
    t_wr;
    t_rst;
    t_fill;
    report_and_stop;
  end
  // generous: the whole sequence needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
endmodule // mrr_byte_rotator_tb

// File: dv/mrr_host_model.sv
// host-side master model: takes read words off the fifo head
// assumes the head holds while valid is high and ready is low
`timescale 1ns/1ps
module mrr_host_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        i_stall,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_data,
  output wire logic        o_ready,
  output logic      [31:0] o_word,
  output logic      [7:0]  o_count
);
  assign o_ready = !i_stall;
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_count <= 8'h00;
    end else if (i_valid && o_ready) begin
      // whole word kept; lanes past the request are masked by the bench
      o_word  <= i_data;
      o_count <= o_count + 8'h01;
    end
  end
endmodule // mrr_host_model

// File: shared/mrr_consts.vh
// constants for the memory read byte rotator datapath
// assumes inclusion by the design files only; holds definitions, no logic
//
// How it works
// - unaligned read shifts first byte to lane 0
// - boundary-crossing read takes two merged array cycles
// - reads rotate right, writes left, same count
// - both cycles share rotation; first gives low bytes
// - writes only rotate; byte selection happens downstream
// - three rotators: two read, one write
// - one-cycle read uses primary rotator only
// - each rotator steers any byte to four lanes
// - output enable drives primary, enables secondary, blocks write
// - first cycle loads holding register from secondary
// - first-cycle selector keeps wanted holding register bytes
// - second cycle feeds holding register back unchanged
// - second cycle drives selected first-cycle bytes out
// - second longword rotates, selected, joins first bytes
// - code zero no shift, else shift one-three bytes
// - second-cycle flag decoded from special-function code
`ifndef MRR_CONSTS_VH
`define MRR_CONSTS_VH

// ----------------------------------------------------------------------
// datapath shape
// ----------------------------------------------------------------------
`define MRR_DATA_W        32
`define MRR_BYTE_W        8
`define MRR_LANES         4
`define MRR_FIFO_DEPTH    16
`define MRR_FIFO_AW       4

// ----------------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------------
`define MRR_SPF_W         3
`define MRR_SPF_SECOND    3'h5
`define MRR_ALL_LANES     4'hF
`define MRR_HOLD_RST      32'h00000000

`endif
